// *** host_master_model.sv ***
// behavioural bus master and control bits on the far side of the register page
`timescale 1ns/1ps
`default_nettype none

module host_master_model (
   // clock
   input wire logic core_clk,
   // register page access
   output logic [9:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_data,
   // memory command events
   output logic mem_cmd,
   output logic clear_memory_cmd,
   output logic copy_wr_attempt,
   output logic [9:0] copy_addr,
   output logic sample_rate_wr,
   input wire logic wipe_enable_clr,
   // control and setup registers
   output logic mission_enable_n,
   output logic wipe_enable,
   output logic [7:0] sample_rate,
   output logic [15:0] start_delay
);
   // idle values; missions are always allowed from here
   initial begin
      {reg_addr, reg_wr, reg_rd, reg_wr_data} = '0;
      {mem_cmd, clear_memory_cmd, copy_wr_attempt, copy_addr, sample_rate_wr} = '0;
      mission_enable_n = 1'b0;
      {wipe_enable, sample_rate, start_delay} = '0;
   end

   // control register drops the arm bit when the device asks
   always @(posedge core_clk) begin
      if (wipe_enable_clr) begin
         wipe_enable <= 1'b0;
      end
   end

   // one clock edge, entered and left just after a falling edge
   task automatic edge1();
      @(posedge core_clk);
      @(negedge core_clk);
   endtask

   // released lines show the inverse of their last value, never a stale copy
   // each access opens with an idle edge so lines released by the last call settle first
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      edge1();
      reg_addr = a;
      reg_wr_data = d;
      reg_wr = 1'b1;
      edge1();
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wr_data = ~d;
   endtask

   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      edge1();
      reg_addr = a;
      reg_rd = 1'b1;
      edge1();
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rd_data;
   endtask

   // arm then clear as the very next access, then let the arm bit fall
   task automatic wipe();
      wipe_enable = 1'b1;
      edge1();
      mem_cmd = 1'b1;
      clear_memory_cmd = 1'b1;
      edge1();
      mem_cmd = 1'b0;
      clear_memory_cmd = 1'b0;
      edge1();
      edge1();
   endtask

   task automatic set_rate(input logic [7:0] rate, input logic [15:0] dly);
      sample_rate = rate;
      start_delay = dly;
      sample_rate_wr = 1'b1;
      edge1();
      sample_rate_wr = 1'b0;
   endtask

   task automatic copy(input logic [9:0] a);
      edge1();
      copy_addr = a;
      copy_wr_attempt = 1'b1;
      mem_cmd = 1'b1;
      edge1();
      copy_wr_attempt = 1'b0;
      mem_cmd = 1'b0;
      copy_addr = ~a;
   endtask
endmodule

`default_nettype wire

// *** mission_status_and_counters.sv ***
// mission status byte, mission time stamp, mission and lifetime sample counters
//
// Overview of operation
// RULE1: status byte lives at 214h; writing it does not always end a mission.
// RULE2: status bits 7..0: busy_n, wiped, mission, sample, zero, low, high, timer alarm.
// RULE3: host writes only clear mission and alarm bits; other status bits ignore writes.
// RULE4: busy_n drops before any conversion, rises after result latched.
// RULE5: memory_wiped reads 1 after Clear Memory zeroed stamp and mission count.
// RULE6: memory_wiped returns to 0 when a nonzero rate write starts a mission.
// RULE7: a mission cannot start unless memory was wiped first.
// RULE8: nonzero sample rate write with mission_enable_n low starts mission.
// RULE9: copy write attempt to 200h..213h ends an active mission.
// RULE10: writing 0 to mission bit ends mission; host cannot set it.
// RULE11: sample_running is 1 during mission conversion, rising 250ms before conversion.
// RULE12: mission conversion including wake-up lasts at most 875ms.
// RULE13: low alarm set when mission sample <= low threshold; host clears with 0.
// RULE14: high alarm set when mission sample >= high threshold; host clears with 0.
// RULE15: timer alarm set on every clock alarm; host clears with 0.
// RULE16: at mission start copy five clock bytes into the time stamp.
// RULE17: first sample after rate plus delay minutes, then every rate minutes.
// RULE18: stamp bytes hold BCD time fields with unused upper bits zero.
// RULE19: 24-bit mission sample count, zeroed by Clear Memory.
// RULE20: 24-bit lifetime sample count, never reset by the host.
// RULE21: host keeps mission_enable_n low to allow a mission start.
// RULE22: host sets wipe_enable then clears; device drops wipe_enable on next command.
// RULE23: each mission conversion increments mission and lifetime counts by one.
// RULE24: a hardware set beats a host clear in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mission_status_consts.svh"

module mission_status_and_counters #(
   parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES,
   parameter int unsigned CONV_MAX_CYCLES = `CONV_MAX_CYCLES,
   parameter int unsigned TIMER_W = 25
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register page access from the memory command engine
   input wire logic [9:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_data,
   // memory command events
   input wire logic mem_cmd,
   input wire logic clear_memory_cmd,
   input wire logic copy_wr_attempt,
   input wire logic [9:0] copy_addr,
   input wire logic sample_rate_wr,
   output logic wipe_enable_clr,
   // settings held in neighbouring registers
   input wire logic mission_enable_n,
   input wire logic wipe_enable,
   input wire logic [7:0] sample_rate,
   input wire logic [15:0] start_delay,
   input wire logic [7:0] low_threshold,
   input wire logic [7:0] high_threshold,
   // real-time clock
   input wire logic minute_tick,
   input wire logic rtc_alarm,
   input wire logic [7:0] rtc_minutes,
   input wire logic [7:0] rtc_hours,
   input wire logic [7:0] rtc_date,
   input wire logic [7:0] rtc_month,
   input wire logic [7:0] rtc_year,
   // temperature core
   input wire logic conv_cmd,
   input wire logic conv_done,
   input wire logic [7:0] conv_result,
   output logic conv_start,
   // status bits
   output logic conv_busy_n,
   output logic memory_wiped,
   output logic mission_running,
   output logic sample_running,
   output logic low_alarm_flag,
   output logic high_alarm_flag,
   output logic timer_alarm_flag
);

   mission_status_pkg::conv_state_t state;
   logic [TIMER_W-1:0] conv_timer;
   logic [16:0] minute_left;
   logic [7:0] stamp_minutes, stamp_hours, stamp_date, stamp_month, stamp_year;
   logic [23:0] mission_count, lifetime_count;
   logic status_wr, start_ok, stop_req, mission_trigger, mission_done, any_done;
   logic timed_out;

   // true when addr falls inside [lo, hi]
   function automatic logic in_span(input logic [9:0] addr, input logic [9:0] lo,
                                    input logic [9:0] hi);
      in_span = (addr >= lo) && (addr <= hi);
   endfunction

   // event decode shared by the flag and counter processes
   assign status_wr = reg_wr && (reg_addr == `ADDR_STATUS); // RULE1
   assign start_ok = sample_rate_wr && (sample_rate != 8'h00) && !mission_enable_n
                     && memory_wiped && !mission_running; // RULE7 RULE8 RULE21
   assign stop_req = (copy_wr_attempt && in_span(copy_addr, `ADDR_COPY_LO, `ADDR_COPY_HI))
                     || (status_wr && !reg_wr_data[`BIT_MISSION_RUNNING]); // RULE9 RULE10
   assign timed_out = (conv_timer == TIMER_W'(CONV_MAX_CYCLES - 1));
   assign mission_done = (state == mission_status_pkg::CONV_MISSION) && conv_done;
   assign any_done = mission_done || ((state == mission_status_pkg::CONV_COMMAND) && conv_done);
   assign mission_trigger = mission_running && !stop_req && minute_tick
                            && (minute_left <= 17'h00001)
                            && (state == mission_status_pkg::CONV_IDLE);

   // mission running and memory wiped bits; a start wins over a stop in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mission_running <= 1'b0;
         memory_wiped <= 1'b0;
      end else begin
         if (start_ok) begin
            mission_running <= 1'b1; // RULE8
            memory_wiped <= 1'b0; // RULE6
         end else begin
            if (stop_req) begin
               mission_running <= 1'b0; // RULE9 RULE10
            end
            if (clear_memory_cmd && wipe_enable && !mission_running) begin
               memory_wiped <= 1'b1; // RULE5
            end
         end
      end
   end

   // the device drops the wipe enable at every memory command
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wipe_enable_clr <= 1'b0;
      end else begin
         wipe_enable_clr <= mem_cmd && wipe_enable; // RULE22
      end
   end

   // alarm flags: hardware set beats a host write of 0 in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         low_alarm_flag <= 1'b0;
         high_alarm_flag <= 1'b0;
         timer_alarm_flag <= 1'b0;
      end else begin
         if (mission_done && (conv_result <= low_threshold)) begin
            low_alarm_flag <= 1'b1; // RULE13 RULE24
         end else if (status_wr && !reg_wr_data[`BIT_LOW_ALARM]) begin
            low_alarm_flag <= 1'b0; // RULE3
         end
         if (mission_done && (conv_result >= high_threshold)) begin
            high_alarm_flag <= 1'b1; // RULE14 RULE24
         end else if (status_wr && !reg_wr_data[`BIT_HIGH_ALARM]) begin
            high_alarm_flag <= 1'b0; // RULE3
         end
         if (rtc_alarm) begin
            timer_alarm_flag <= 1'b1; // RULE15 RULE24
         end else if (status_wr && !reg_wr_data[`BIT_TIMER_ALARM]) begin
            timer_alarm_flag <= 1'b0; // RULE3
         end
      end
   end

   // minute countdown to the next mission sample, aligned to minute ticks
   always_ff @(posedge core_clk) begin
      if (rst) begin
         minute_left <= 17'h00000;
      end else if (start_ok) begin
         minute_left <= 17'(sample_rate) + 17'(start_delay); // RULE17
      end else if (mission_running && minute_tick) begin
         if (minute_left <= 17'h00001) begin
            minute_left <= 17'(sample_rate); // RULE17
         end else begin
            minute_left <= minute_left - 17'h00001;
         end
      end
   end

   // conversion sequencer: wake-up then conversion for a mission sample, conversion alone on command, bounded by the maximum time
   // a core that never answers would otherwise hold busy_n low forever
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= mission_status_pkg::CONV_IDLE;
         conv_timer <= '0;
         conv_start <= 1'b0;
         conv_busy_n <= 1'b1;
         sample_running <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         conv_timer <= conv_timer + TIMER_W'(1);
         case (state)
            mission_status_pkg::CONV_IDLE: begin
               conv_timer <= '0;
               if (mission_trigger) begin
                  state <= mission_status_pkg::CONV_WAKE;
                  sample_running <= 1'b1; // RULE11
               end else if (conv_cmd) begin
                  state <= mission_status_pkg::CONV_COMMAND;
                  conv_start <= 1'b1;
                  conv_busy_n <= 1'b0; // RULE4
               end
            end
            mission_status_pkg::CONV_WAKE: begin
               if (conv_timer == TIMER_W'(WAKE_CYCLES - 1)) begin
                  state <= mission_status_pkg::CONV_MISSION;
                  conv_start <= 1'b1; // RULE11
                  conv_busy_n <= 1'b0; // RULE4
               end
            end
            mission_status_pkg::CONV_MISSION, mission_status_pkg::CONV_COMMAND: begin
               if (conv_done || timed_out) begin
                  state <= mission_status_pkg::CONV_IDLE;
                  conv_busy_n <= 1'b1; // RULE4 RULE12
                  sample_running <= 1'b0; // RULE12
               end
            end
            default: begin
               state <= mission_status_pkg::CONV_IDLE;
               conv_busy_n <= 1'b1;
               sample_running <= 1'b0;
            end
         endcase
      end
   end

   // mission time stamp, taken from the clock at mission start, zeroed by a wipe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stamp_minutes <= `RESET_BYTE;
         stamp_hours <= `RESET_BYTE;
         stamp_date <= `RESET_BYTE;
         stamp_month <= `RESET_BYTE;
         stamp_year <= `RESET_BYTE;
      end else if (start_ok) begin
         stamp_minutes <= {1'b0, rtc_minutes[6:0]}; // RULE16 RULE18
         stamp_hours <= {1'b0, rtc_hours[6:0]}; // RULE16 RULE18
         stamp_date <= {2'b00, rtc_date[5:0]}; // RULE16 RULE18
         stamp_month <= {3'b000, rtc_month[4:0]}; // RULE16 RULE18
         stamp_year <= rtc_year; // RULE16
      end else if (clear_memory_cmd && wipe_enable && !mission_running) begin
         stamp_minutes <= `RESET_BYTE; // RULE5
         stamp_hours <= `RESET_BYTE;
         stamp_date <= `RESET_BYTE;
         stamp_month <= `RESET_BYTE;
         stamp_year <= `RESET_BYTE;
      end
   end

   // sample counters; the lifetime count sees every conversion and no host clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mission_count <= `RESET_COUNT;
      end else if (clear_memory_cmd && wipe_enable && !mission_running) begin
         mission_count <= `RESET_COUNT; // RULE19
      end else if (mission_done) begin
         mission_count <= mission_count + 24'h000001; // RULE23
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         lifetime_count <= `RESET_COUNT;
      end else if (any_done) begin
         lifetime_count <= lifetime_count + 24'h000001; // RULE20 RULE23
      end
   end

   // read mux, registered; unmapped offsets read zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rd_data <= `RESET_BYTE;
      end else if (reg_rd) begin
         case (reg_addr)
            `ADDR_STATUS: reg_rd_data <= {conv_busy_n, memory_wiped, mission_running,
                                          sample_running, 1'b0, low_alarm_flag,
                                          high_alarm_flag, timer_alarm_flag}; // RULE2
            `ADDR_STAMP_MIN: reg_rd_data <= stamp_minutes;
            `ADDR_STAMP_HOUR: reg_rd_data <= stamp_hours;
            `ADDR_STAMP_DATE: reg_rd_data <= stamp_date;
            `ADDR_STAMP_MONTH: reg_rd_data <= stamp_month;
            `ADDR_STAMP_YEAR: reg_rd_data <= stamp_year;
            `ADDR_MCOUNT_LO: reg_rd_data <= mission_count[7:0]; // RULE19
            `ADDR_MCOUNT_MID: reg_rd_data <= mission_count[15:8];
            `ADDR_MCOUNT_HI: reg_rd_data <= mission_count[23:16];
            `ADDR_LCOUNT_LO: reg_rd_data <= lifetime_count[7:0]; // RULE20
            `ADDR_LCOUNT_MID: reg_rd_data <= lifetime_count[15:8];
            `ADDR_LCOUNT_HI: reg_rd_data <= lifetime_count[23:16];
            default: reg_rd_data <= `RESET_BYTE;
         endcase
      end
   end

   // checks on the status, sequencing and counting behaviour
   property p_status_unused_zero;
      @(posedge core_clk) disable iff (rst)
         (reg_rd && reg_addr == `ADDR_STATUS) |=> (reg_rd_data[3] == 1'b0)
            && (reg_rd_data[5] == $past(mission_running));
   endproperty
   a_status_unused_zero: assert property (p_status_unused_zero) // RULE2
      else $error("bad status read");

   property p_mission_rise_cause;
      @(posedge core_clk) disable iff (rst)
         $rose(mission_running) |-> $past(memory_wiped) && !memory_wiped;
   endproperty
   a_mission_rise_cause: assert property (p_mission_rise_cause) // RULE7
      else $error("bad mission start");

   property p_copy_ends;
      @(posedge core_clk) disable iff (rst)
         (copy_wr_attempt && copy_addr >= `ADDR_COPY_LO && copy_addr <= `ADDR_COPY_HI
          && !start_ok) |=> !mission_running;
   endproperty
   a_copy_ends: assert property (p_copy_ends) else $error("copy did not end mission"); // RULE9

   property p_busy_release;
      @(posedge core_clk) disable iff (rst)
         (conv_done && !conv_busy_n) |=> conv_busy_n;
   endproperty
   a_busy_release: assert property (p_busy_release) else $error("busy stuck low"); // RULE4

   property p_wake_lead;
      @(posedge core_clk) disable iff (rst)
         (conv_start && sample_running) |-> $past(sample_running, 2);
   endproperty
   a_wake_lead: assert property (p_wake_lead) else $error("no wake before conversion"); // RULE11

   property p_low_alarm;
      @(posedge core_clk) disable iff (rst)
         (mission_done && conv_result <= low_threshold) |=> low_alarm_flag;
   endproperty
   a_low_alarm: assert property (p_low_alarm) else $error("low alarm missed"); // RULE13

   property p_high_alarm;
      @(posedge core_clk) disable iff (rst)
         (mission_done && conv_result >= high_threshold) |=> high_alarm_flag;
   endproperty
   a_high_alarm: assert property (p_high_alarm) else $error("high alarm missed"); // RULE14

   property p_timer_alarm;
      @(posedge core_clk) disable iff (rst)
         rtc_alarm |=> timer_alarm_flag;
   endproperty
   a_timer_alarm: assert property (p_timer_alarm) else $error("timer alarm missed"); // RULE15

   property p_stamp_copy;
      @(posedge core_clk) disable iff (rst)
         start_ok |=> (stamp_year == $past(rtc_year))
            && (stamp_minutes[6:0] == $past(rtc_minutes[6:0]));
   endproperty
   a_stamp_copy: assert property (p_stamp_copy) else $error("stamp not copied"); // RULE16

   property p_count_step;
      @(posedge core_clk) disable iff (rst)
         (mission_done && !(clear_memory_cmd && wipe_enable && !mission_running))
            |=> (mission_count == $past(mission_count) + 24'h000001)
            && (lifetime_count == $past(lifetime_count) + 24'h000001);
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter step wrong"); // RULE23

   // wake plus conversion never outlasts the bound, even if the core stays silent
   property p_conv_bounded;
      @(posedge core_clk) disable iff (rst)
         (sample_running || !conv_busy_n) |-> (conv_timer < TIMER_W'(CONV_MAX_CYCLES));
   endproperty
   a_conv_bounded: assert property (p_conv_bounded) // RULE12
      else $error("conversion overran");

   c_mission_start: cover property (@(posedge core_clk) disable iff (rst) $rose(mission_running));
   c_mission_conv: cover property (@(posedge core_clk) disable iff (rst) mission_done);
   c_command_conv: cover property (@(posedge core_clk) disable iff (rst)
      (state == mission_status_pkg::CONV_COMMAND) && conv_done);
   c_set_beats_clear: cover property (@(posedge core_clk) disable iff (rst)
      rtc_alarm && status_wr && !reg_wr_data[0]);

endmodule
`default_nettype wire

// *** mission_status_and_counters_bench.sv ***
// self-checking bench for the mission status and counters block
`timescale 1ns/1ps
`default_nettype none
`include "mission_status_consts.svh"

module mission_status_and_counters_bench;
   // clock, reset and bench-driven inputs
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic minute_tick = 1'b0;
   logic rtc_alarm = 1'b0;
   logic [7:0] rtc_minutes = 8'hd9;
   logic [7:0] rtc_hours = 8'hff;
   logic [7:0] rtc_date = 8'hff;
   logic [7:0] rtc_month = 8'hff;
   logic [7:0] rtc_year = 8'h99;
   logic [7:0] low_threshold = 8'h10;
   logic [7:0] high_threshold = 8'h80;
   logic conv_cmd = 1'b0;
   logic conv_done = 1'b0;
   logic [7:0] conv_result = 8'h00;
   // master side nets and design outputs
   logic [9:0] reg_addr, copy_addr;
   logic [7:0] reg_wr_data, reg_rd_data, sample_rate;
   logic [15:0] start_delay;
   logic reg_wr, reg_rd, mem_cmd, clear_memory_cmd, copy_wr_attempt, sample_rate_wr;
   logic wipe_enable_clr, mission_enable_n, wipe_enable, conv_start;
   logic conv_busy_n, memory_wiped, mission_running, sample_running;
   logic low_alarm_flag, high_alarm_flag, timer_alarm_flag;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] b;
   logic [23:0] c;

   always #25 core_clk = ~core_clk;

   // short wake and timeout counts keep the run brief
   mission_status_and_counters #(.WAKE_CYCLES(4), .CONV_MAX_CYCLES(20)) dut_u (
      .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .mem_cmd(mem_cmd),
      .clear_memory_cmd(clear_memory_cmd), .copy_wr_attempt(copy_wr_attempt),
      .copy_addr(copy_addr), .sample_rate_wr(sample_rate_wr), .wipe_enable_clr(wipe_enable_clr),
      .mission_enable_n(mission_enable_n), .wipe_enable(wipe_enable),
      .sample_rate(sample_rate), .start_delay(start_delay), .low_threshold(low_threshold),
      .high_threshold(high_threshold), .minute_tick(minute_tick), .rtc_alarm(rtc_alarm),
      .rtc_minutes(rtc_minutes), .rtc_hours(rtc_hours), .rtc_date(rtc_date),
      .rtc_month(rtc_month), .rtc_year(rtc_year), .conv_cmd(conv_cmd), .conv_done(conv_done),
      .conv_result(conv_result), .conv_start(conv_start), .conv_busy_n(conv_busy_n),
      .memory_wiped(memory_wiped), .mission_running(mission_running),
      .sample_running(sample_running), .low_alarm_flag(low_alarm_flag),
      .high_alarm_flag(high_alarm_flag), .timer_alarm_flag(timer_alarm_flag));

   host_master_model host_u (
      .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .mem_cmd(mem_cmd),
      .clear_memory_cmd(clear_memory_cmd), .copy_wr_attempt(copy_wr_attempt),
      .copy_addr(copy_addr), .sample_rate_wr(sample_rate_wr), .wipe_enable_clr(wipe_enable_clr),
      .mission_enable_n(mission_enable_n), .wipe_enable(wipe_enable),
      .sample_rate(sample_rate), .start_delay(start_delay));

   task automatic test_done();
      if (err_total == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // a hang ends the run as a mismatch
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         err_total++;
         test_done();
      end
   end

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask

   task automatic chk_cnt(input logic [9:0] lo, input logic [23:0] exp);
      logic [7:0] d0, d1, d2;
      host_u.rd(lo, d0);
      host_u.rd(lo + 10'h001, d1);
      host_u.rd(lo + 10'h002, d2);
      chk_byte(d0, exp[7:0]);
      chk_byte(d1, exp[15:8]);
      chk_byte(d2, exp[23:16]);
   endtask

   task automatic cyc(input int n);
      repeat (n) host_u.edge1();
   endtask

   task automatic status_is(input logic [7:0] exp);
      logic [7:0] d;
      host_u.rd(`ADDR_STATUS, d);
      chk_byte(d, exp);
   endtask

   // minute ticks up to a mission sample, then wake, convert and latch
   task automatic run_sample(input int ticks, input logic [7:0] res);
      repeat (ticks - 1) begin
         minute_tick = 1'b1;
         cyc(1);
         minute_tick = 1'b0;
         chk_bit(sample_running, 1'b0);
      end
      minute_tick = 1'b1;
      cyc(1);
      minute_tick = 1'b0;
      chk_bit(sample_running, 1'b1);
      chk_bit(conv_busy_n, 1'b1);
      for (int i = 0; i < 40 && conv_start !== 1'b1; i++) cyc(1);
      chk_bit(conv_start, 1'b1);
      chk_bit(conv_busy_n, 1'b0);
      conv_result = res;
      conv_done = 1'b1;
      cyc(1);
      conv_done = 1'b0;
      chk_bit(conv_busy_n, 1'b1);
      chk_bit(sample_running, 1'b0);
   endtask

   initial begin
      cyc(12);
      rst = 1'b0;
      // reset state, unmapped place and lifetime counter
      status_is(8'h80);
      host_u.rd(10'h300, b);
      chk_byte(b, 8'h00);
      chk_cnt(`ADDR_LCOUNT_LO, 24'h000000);
      // a start without a wipe is refused
      host_u.set_rate(8'h02, 16'h0001);
      status_is(8'h80);
      host_u.wipe();
      chk_bit(wipe_enable, 1'b0);
      status_is(8'hc0);
      host_u.wr(`ADDR_STATUS, 8'hff);
      status_is(8'hc0);
      // start: stamp taken with upper bits masked
      host_u.set_rate(8'h02, 16'h0001);
      chk_bit(mission_running, 1'b1);
      chk_bit(memory_wiped, 1'b0);
      rtc_minutes = 8'h00;
      host_u.rd(`ADDR_STAMP_MIN, b);
      chk_byte(b, 8'h59);
      host_u.rd(`ADDR_STAMP_HOUR, b);
      chk_byte(b, 8'h7f);
      host_u.rd(`ADDR_STAMP_DATE, b);
      chk_byte(b, 8'h3f);
      host_u.rd(`ADDR_STAMP_MONTH, b);
      chk_byte(b, 8'h1f);
      host_u.rd(`ADDR_STAMP_YEAR, b);
      chk_byte(b, 8'h99);
      // first sample after rate plus delay minutes, equal to the low limit
      run_sample(3, 8'h10);
      status_is(8'ha4);
      chk_cnt(`ADDR_MCOUNT_LO, 24'h000001);
      host_u.wr(`ADDR_STATUS, 8'hfb);
      status_is(8'ha0);
      // next sample after rate minutes, equal to the high limit
      run_sample(2, 8'h80);
      status_is(8'ha2);
      chk_cnt(`ADDR_LCOUNT_LO, 24'h000002);
      // timer alarm set, cleared, then set while a clear is written in the same cycle
      rtc_alarm = 1'b1;
      cyc(1);
      rtc_alarm = 1'b0;
      status_is(8'ha3);
      host_u.wr(`ADDR_STATUS, 8'hfe);
      status_is(8'ha2);
      rtc_alarm = 1'b1;
      host_u.wr(`ADDR_STATUS, 8'hfe);
      rtc_alarm = 1'b0;
      status_is(8'ha3);
      // copy just outside the range keeps the mission, the top of it ends it
      host_u.copy(`ADDR_STATUS);
      chk_bit(mission_running, 1'b1);
      host_u.copy(`ADDR_COPY_HI);
      status_is(8'h83);
      host_u.set_rate(8'h01, 16'h0000);
      status_is(8'h83);
      host_u.wr(`ADDR_STATUS, 8'h00);
      status_is(8'h80);
      // second wipe zeroes stamp and mission count, lifetime count stays
      host_u.wipe();
      host_u.rd(`ADDR_STAMP_MIN, b);
      chk_byte(b, 8'h00);
      chk_cnt(`ADDR_MCOUNT_LO, 24'h000000);
      chk_cnt(`ADDR_LCOUNT_LO, 24'h000002);
      host_u.set_rate(8'h01, 16'h0000);
      status_is(8'ha0);
      // a silent core: the sequencer gives up and nothing is counted
      minute_tick = 1'b1;
      cyc(1);
      minute_tick = 1'b0;
      cyc(30);
      status_is(8'ha0);
      chk_cnt(`ADDR_MCOUNT_LO, 24'h000000);
      host_u.wr(`ADDR_STATUS, 8'hdf);
      status_is(8'h80);
      host_u.wr(`ADDR_STATUS, 8'hff);
      status_is(8'h80);
      // command conversion counts only the lifetime and raises no alarm
      conv_cmd = 1'b1;
      cyc(1);
      conv_cmd = 1'b0;
      for (int i = 0; i < 10 && conv_start !== 1'b1; i++) cyc(1);
      chk_bit(conv_busy_n, 1'b0);
      conv_result = 8'h00;
      conv_done = 1'b1;
      cyc(1);
      conv_done = 1'b0;
      status_is(8'h80);
      chk_cnt(`ADDR_LCOUNT_LO, 24'h000003);
      chk_cnt(`ADDR_MCOUNT_LO, 24'h000000);
      test_done();
   end
endmodule

`default_nettype wire

// *** mission_status_consts.svh ***
// register offsets, status bit positions and timing figures for the mission status block
`ifndef MISSION_STATUS_CONSTS_SVH
`define MISSION_STATUS_CONSTS_SVH

// register page offsets
`define ADDR_COPY_LO 10'h200
`define ADDR_COPY_HI 10'h213
`define ADDR_STATUS 10'h214
`define ADDR_STAMP_MIN 10'h215
`define ADDR_STAMP_HOUR 10'h216
`define ADDR_STAMP_DATE 10'h217
`define ADDR_STAMP_MONTH 10'h218
`define ADDR_STAMP_YEAR 10'h219
`define ADDR_MCOUNT_LO 10'h21a
`define ADDR_MCOUNT_MID 10'h21b
`define ADDR_MCOUNT_HI 10'h21c
`define ADDR_LCOUNT_LO 10'h21d
`define ADDR_LCOUNT_MID 10'h21e
`define ADDR_LCOUNT_HI 10'h21f

// status byte bit positions
`define BIT_CONV_BUSY_N 7
`define BIT_MEMORY_WIPED 6
`define BIT_MISSION_RUNNING 5
`define BIT_SAMPLE_RUNNING 4
`define BIT_UNUSED 3
`define BIT_LOW_ALARM 2
`define BIT_HIGH_ALARM 1
`define BIT_TIMER_ALARM 0

// reset values
`define RESET_BYTE 8'h00
`define RESET_COUNT 24'h000000

// timing: figures in ms, clock rate in kHz
`define CLK_KHZ 20000
`define WAKE_MS 250
`define CONV_MAX_MS 875
`define WAKE_CYCLES (`WAKE_MS * `CLK_KHZ)
`define CONV_MAX_CYCLES (`CONV_MAX_MS * `CLK_KHZ)

`endif

// *** mission_status_pkg.sv ***
// types shared by the mission status block
package mission_status_pkg;
   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_WAKE,
      CONV_MISSION,
      CONV_COMMAND
   } conv_state_t;
endpackage
